/* File: rtl/nibble_swap_xor_direction_load_op_exec.v */
/*
 * Execution datapath for nibble swap, direction load and exclusive-OR
 * (immediate and file). Owns the working register, the zero flag and
 * the three port direction registers; writes to the data file are
 * issued as a registered write strobe.
 * Assumes the decoder presents a one-cycle operation strobe with its
 * operands, and the data file supplies the addressed byte in the same
 * cycle on I_FILE_RDATA.
 */
`include "nswx_map.vh"

module nibble_swap_xor_direction_load_op_exec (
   input  wire       I_CLK_SYS,
   input  wire       I_RESETN,
   input  wire       i_op_valid,
   input  wire [2:0] i_op_code,
   input  wire [6:0] i_op_addr,
   input  wire       i_op_dest,
   input  wire [7:0] i_op_literal,
   input  wire [7:0] i_file_rdata,
   output reg        o_file_we,
   output reg  [6:0] o_file_waddr,
   output reg  [7:0] o_file_wdata,
   output reg  [7:0] o_work,
   output reg        o_zero,
   output reg        o_illegal,
   output wire [7:0] o_port_a_direction,
   output wire [7:0] o_port_b_direction,
   output wire [7:0] o_port_c_direction
);

   // ****************************************************
   // Helpers
   // ****************************************************
   function [7:0] nibble_swap;
      input [7:0] b;
      begin
         nibble_swap = {b[3:0], b[7:4]};
      end
   endfunction

   function dir_sel_ok;
      input [6:0] a;
      begin
         dir_sel_ok = (a >= `DIR_SEL_A) && (a <= `DIR_SEL_C);
      end
   endfunction

   // ****************************************************
   // Combinational execute
   // ****************************************************
   reg       file_we_nxt;
   reg [7:0] file_wdata_nxt;
   reg [7:0] work_nxt;
   reg       zero_nxt;
   reg       illegal_nxt;
   reg       dir_we;
   reg [1:0] dir_sel;
   reg [7:0] result;

   always @* begin
      file_we_nxt    = 1'b0;
      file_wdata_nxt = o_file_wdata;
      work_nxt       = o_work;
      zero_nxt       = o_zero;
      illegal_nxt    = 1'b0;
      dir_we         = 1'b0;
      dir_sel        = 2'd0;
      result         = 8'h00;
      if (i_op_valid) begin
         case (i_op_code)
            `OP_NIBBLE_SWAP: begin
               result = nibble_swap(i_file_rdata);
               if (i_op_dest == `DEST_WORK) begin
                  work_nxt = result;
               end else begin
                  file_we_nxt    = 1'b1;
                  file_wdata_nxt = result;
               end
            end
            `OP_DIRECTION_LOAD: begin
               if (dir_sel_ok(i_op_addr)) begin
                  dir_we  = 1'b1;
                  dir_sel = i_op_addr[1:0] - 2'd1;
               end else begin
                  illegal_nxt = 1'b1;
               end
            end
            `OP_XOR_IMMEDIATE: begin
               result   = o_work ^ i_op_literal;
               work_nxt = result;
               zero_nxt = (result == 8'h00);
            end
            `OP_XOR_FILE: begin
               result   = o_work ^ i_file_rdata;
               zero_nxt = (result == 8'h00);
               if (i_op_dest == `DEST_WORK) begin
                  work_nxt = result;
               end else begin
                  file_we_nxt    = 1'b1;
                  file_wdata_nxt = result;
               end
            end
            default: begin
               illegal_nxt = (i_op_code != `OP_NONE);
            end
         endcase
      end
   end

   // ****************************************************
   // State registers
   // ****************************************************
   always @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         o_file_we    <= 1'b0;
         o_file_waddr <= 7'h00;
         o_file_wdata <= 8'h00;
         o_work       <= `WORK_RESET;
         o_zero       <= `ZERO_RESET;
         o_illegal    <= 1'b0;
      end else begin
         o_file_we    <= file_we_nxt;
         o_file_waddr <= i_op_addr;
         o_file_wdata <= file_wdata_nxt;
         o_work       <= work_nxt;
         o_zero       <= zero_nxt;
         o_illegal    <= illegal_nxt;
      end
   end

   // ****************************************************
   // Port direction registers
   // ****************************************************
   dir_regs u_dir_regs (
      .i_clk    (I_CLK_SYS),
      .i_resetn (I_RESETN),
      .i_we     (dir_we),
      .i_sel    (dir_sel),
      .i_data   (o_work),
      .o_dir_a  (o_port_a_direction),
      .o_dir_b  (o_port_b_direction),
      .o_dir_c  (o_port_c_direction)
   );

endmodule

/* File: rtl/nswx_map.vh */
/*
 * Constants for the nibble-swap / direction-load / exclusive-OR
 * execution block: operation codes, operand ranges, reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef NSWX_MAP_VH
`define NSWX_MAP_VH

// ****************************************************
// Operation codes from the core decoder
// ****************************************************
`define OP_NONE            3'h0
`define OP_NIBBLE_SWAP     3'h1
`define OP_DIRECTION_LOAD  3'h2
`define OP_XOR_IMMEDIATE   3'h3
`define OP_XOR_FILE        3'h4

// ****************************************************
// Operand ranges and selectors
// ****************************************************
`define FILE_ADDR_MAX      7'h7F
`define DIR_SEL_A          7'h05
`define DIR_SEL_B          7'h06
`define DIR_SEL_C          7'h07

// ****************************************************
// Destination bit and reset values
// ****************************************************
`define DEST_WORK          1'b0
`define DEST_FILE          1'b1
`define WORK_RESET         8'h00
`define DIR_RESET          8'hFF
`define ZERO_RESET         1'b0

`endif

/* File: rtl/dir_regs.v */
/*
 * Three port direction registers, written one at a time.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`include "nswx_map.vh"

module dir_regs (
   input  wire       i_clk,
   input  wire       i_resetn,
   input  wire       i_we,
   input  wire [1:0] i_sel,
   input  wire [7:0] i_data,
   output wire [7:0] o_dir_a,
   output wire [7:0] o_dir_b,
   output wire [7:0] o_dir_c
);

   reg [7:0] dir_r [0:2];

   // ****************************************************
   // One register per port
   // ****************************************************
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_dir
         always @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               dir_r[g] <= `DIR_RESET;
            end else if (i_we && (i_sel == g)) begin
               dir_r[g] <= i_data;
            end
         end
      end
   endgenerate

   assign o_dir_a = dir_r[0];
   assign o_dir_b = dir_r[1];
   assign o_dir_c = dir_r[2];

endmodule

/* File: verification/data_file_model.sv */
/* Data file model: 128 bytes, read at once, written on the strobe.
   Assumes the block's clock and its registered write port. */
module data_file_model (
   input  wire       i_clk, i_we,
   input  wire [6:0] i_addr, i_waddr,
   input  wire [7:0] i_wdata,
   output wire [7:0] o_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [128];
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 3);
   assign o_rdata = mem[i_addr];
   always @(posedge i_clk) if (i_we) mem[i_waddr] <= i_wdata;
endmodule

/* File: verification/nswx_monitor.sv */
/* Checker bound to the exec block's ports.
   Assumes one clock and the active-low reset. */
module nswx_monitor (
   input wire       I_CLK_SYS, I_RESETN, i_op_valid, i_op_dest,
   input wire       o_file_we, o_zero, o_illegal,
   input wire [2:0] i_op_code,
   input wire [6:0] i_op_addr,
   input wire [7:0] i_op_literal, i_file_rdata, o_file_wdata, o_work,
   input wire [7:0] o_port_b_direction
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);
   wire [2:0] c = i_op_valid ? i_op_code : 3'h0;
   wire [7:0] sw = {i_file_rdata[3:0], i_file_rdata[7:4]};
   wire [7:0] xr = o_work ^ (c == 3'h3 ? i_op_literal : i_file_rdata);
   wire bad = c == 3'h2 && (i_op_addr < 7'h05 || i_op_addr > 7'h07);
   a_swap_work: assert property (c == 3'h1 && !i_op_dest |=>
      o_work == $past(sw)) else $error("swap to W");
   a_swap_file: assert property (c == 3'h1 && i_op_dest |=>
      o_file_we && o_file_wdata == $past(sw)) else $error("swap to file");
   a_swap_flag: assert property (c == 3'h1 |=> $stable(o_zero))
      else $error("swap flag");
   a_dir_load: assert property (c == 3'h2 && i_op_addr == 7'h06 |=>
      o_port_b_direction == $past(o_work)) else $error("dir load");
   a_dir_refuse: assert property (bad |=> o_illegal &&
      $stable(o_port_b_direction)) else $error("dir refuse");
   a_xor_imm: assert property (c == 3'h3 |=> o_work == $past(xr))
      else $error("xor literal");
   a_xor_file: assert property (c == 3'h4 && i_op_dest |=>
      o_file_we && o_file_wdata == $past(xr)) else $error("xor file");
   a_zero_flag: assert property (c == 3'h3 || c == 3'h4 |=>
      o_zero == ($past(xr) == 8'h00)) else $error("zero flag");
   c_swap_file: cover property (c == 3'h1 && i_op_dest);
   c_refused: cover property (bad ##1 o_illegal);
   c_zero_set: cover property (c == 3'h3 ##1 o_zero);
endmodule
bind nibble_swap_xor_direction_load_op_exec nswx_monitor mon (.*);

/* File: verification/nibble_swap_xor_direction_load_op_exec_bench.sv */
/* Self-checking bench for the exec block.
   Assumes the data file model and the bound checker. */
module nibble_swap_xor_direction_load_op_exec_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       I_CLK_SYS = 0, I_RESETN = 0, i_op_valid = 0, i_op_dest = 0;
   logic [2:0] i_op_code = '0;
   logic [6:0] i_op_addr = '0;
   logic [7:0] i_op_literal = '0, w, f, dr [3];
   wire        o_file_we, o_zero, o_illegal;
   wire  [6:0] o_file_waddr;
   wire  [7:0] i_file_rdata, o_file_wdata, o_work, o_port_a_direction;
   wire  [7:0] o_port_b_direction, o_port_c_direction;
   int         errors = 0, n_tests = 0;
   always #2 I_CLK_SYS = ~I_CLK_SYS;
   nibble_swap_xor_direction_load_op_exec dut (.*);
   data_file_model mem (.i_clk(I_CLK_SYS), .i_we(o_file_we),
      .i_addr(i_op_addr), .i_waddr(o_file_waddr), .i_wdata(o_file_wdata),
      .o_rdata(i_file_rdata));
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
      if (g !== e) errors++;
   endtask
   task op(input [2:0] c, input [6:0] a, input d, input [7:0] k);
      @(posedge I_CLK_SYS);
      {i_op_valid, i_op_code, i_op_addr, i_op_dest, i_op_literal} <=
         {1'b1, c, a, d, k};
      #1 f = mem.mem[a];
      @(posedge I_CLK_SYS);
      i_op_valid <= 1'b0;
      #1;
   endtask
   task t_xor;
      op(3'h4, 7'h10, 1, 0);
      chk(o_file_wdata, f);
      chk({7'h00, o_file_we}, 8'h01);
      chk({1'b0, o_file_waddr}, 8'h10);
      chk({7'h00, o_zero}, 8'h00);
      op(3'h4, 7'h7F, 0, 0);
      chk(o_work, f);
      chk({7'h00, o_file_we}, 8'h00);
      w = f;
      op(3'h3, 0, 0, 8'hA5);
      chk(o_work, w ^ 8'hA5);
      chk({7'h00, o_zero}, 8'h00);
      op(3'h3, 0, 0, w ^ 8'hA5);
      chk(o_zero, 1);
   endtask
   task t_swap;
      op(3'h1, 7'h10, 1, 0);
      chk(o_file_wdata, {f[3:0], f[7:4]});
      op(3'h1, 7'h03, 0, 0);
      w = {f[3:0], f[7:4]};
      chk(o_work, w);
      chk(o_zero, 1);
   endtask
   task t_dir;
      dr = '{3{8'hFF}};
      for (int s = 4; s < 9; s++) begin
         op(3'h3, 0, 0, 8'(s * 17));
         w ^= 8'(s * 17);
         op(3'h2, 7'(s), 0, 0);
         if (s > 4 && s < 8) dr[s - 5] = w;
         chk(o_port_a_direction, dr[0]);
         chk(o_port_b_direction, dr[1]);
         chk(o_port_c_direction, dr[2]);
         chk(o_illegal, s < 5 || s > 7);
      end
   endtask
   task close_out;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge I_CLK_SYS);
      I_RESETN <= 1'b1;
      t_xor;
      t_swap;
      t_dir;
      close_out;
   end
endmodule
